/* File: hdl/ppfc_pin_cell.sv */
`default_nettype none
module ppfc_pin_cell import ppfc_pkg::*; #(
	parameter bit HAS_DRIVE_CFG = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic pin_in,
	input wire logic we,
	input wire ppfc_field_t field,
	input wire logic wd,
	input wire logic alt_en,
	input wire logic alt_data,
	output logic pin_out,
	output logic pin_oe,
	output logic pull_en,
	output logic rd,
	output logic sync
);
	logic dir_r, dir_nxt, plu_r, plu_nxt, odc_r, odc_nxt, fsel_r, fsel_nxt, lat_r, lat_nxt;
	logic meta_r, sync_r, out_r, out_nxt, oe_r, oe_nxt, pu_r, pu_nxt, rd_r, rd_nxt;
	logic val;

	always_comb begin
		dir_nxt = dir_r;
		plu_nxt = plu_r;
		odc_nxt = odc_r;
		fsel_nxt = fsel_r;
		lat_nxt = lat_r;
		if (we) begin
			case (field)
				PPFC_FLD_LATCH: lat_nxt = wd;
				PPFC_FLD_DIR: dir_nxt = wd;
				PPFC_FLD_PULLUP: plu_nxt = wd;
				PPFC_FLD_DRIVE: odc_nxt = wd & HAS_DRIVE_CFG;
				PPFC_FLD_FSEL: fsel_nxt = wd;
				default: lat_nxt = lat_r;
			endcase
		end
		if (clr) begin
			dir_nxt = 1'b0;
			plu_nxt = 1'b0;
			odc_nxt = 1'b0;
			fsel_nxt = 1'b0;
			lat_nxt = 1'b0;
		end
		// peripheral drives only with the function select set, else the latch
		val = (fsel_r & alt_en) ? alt_data : lat_r;
		// open drain pulls low only; a high releases the wire, with the pull-up held off while dir is set
		oe_nxt = dir_r & (~odc_r | ~val);
		out_nxt = val & ~odc_r;
		pu_nxt = plu_r & ~dir_r;
		rd_nxt = dir_r ? lat_r : sync_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_r <= 1'b0;
			plu_r <= 1'b0;
			odc_r <= 1'b0;
			fsel_r <= 1'b0;
			lat_r <= 1'b0;
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			out_r <= 1'b0;
			oe_r <= 1'b0;
			pu_r <= 1'b0;
			rd_r <= 1'b0;
		end else begin
			dir_r <= dir_nxt;
			plu_r <= plu_nxt;
			odc_r <= odc_nxt;
			fsel_r <= fsel_nxt;
			lat_r <= lat_nxt;
			meta_r <= pin_in;
			sync_r <= meta_r;
			out_r <= out_nxt;
			oe_r <= oe_nxt;
			pu_r <= pu_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign pin_out = out_r;
	assign pin_oe = oe_r;
	assign pull_en = pu_r;
	assign rd = rd_r;
	assign sync = sync_r;
endmodule : ppfc_pin_cell
`default_nettype wire

/* File: hdl/ppfc_pkg.sv */
`default_nettype none
package ppfc_pkg;
	localparam int PPFC_NBITS = 72;
	localparam int PPFC_NCH = 4;
	// flat pin index of bit 0 of each port; port 3 starts at P33, port 4 at P43, port 6 at P61
	localparam int PPFC_P0_OFS = 0;
	localparam int PPFC_P1_OFS = 7;
	localparam int PPFC_P2_OFS = 8;
	localparam int PPFC_P3_OFS = 15;
	localparam int PPFC_P4_OFS = 18;
	localparam int PPFC_P5_OFS = 23;
	localparam int PPFC_P6_OFS = 31;
	localparam int PPFC_P7_OFS = 38;
	localparam int PPFC_P8_OFS = 46;
	localparam int PPFC_P9_OFS = 54;
	localparam int PPFC_PA_OFS = 60;
	localparam int PPFC_PB_OFS = 68;
	// serial channel slots 0..3 stand for interfaces 0, 1, 2 and 4
	localparam int PPFC_TX_IDX [PPFC_NCH] = '{PPFC_P5_OFS + 0, PPFC_P0_OFS + 1, PPFC_P7_OFS + 0, PPFC_P6_OFS + 4};
	localparam int PPFC_RX_IDX [PPFC_NCH] = '{PPFC_P5_OFS + 1, PPFC_P0_OFS + 0, PPFC_P7_OFS + 1, PPFC_P6_OFS + 3};
	localparam int PPFC_CK_IDX [PPFC_NCH] = '{PPFC_P5_OFS + 2, PPFC_P0_OFS + 2, PPFC_P7_OFS + 2, PPFC_P6_OFS + 5};
	localparam logic [PPFC_NCH-1:0] PPFC_UART_CAP = 4'h7;
	localparam int PPFC_I2C_CH = 3;
	typedef enum logic [2:0] {
		PPFC_FLD_LATCH = 3'h0,
		PPFC_FLD_DIR = 3'h1,
		PPFC_FLD_PULLUP = 3'h2,
		PPFC_FLD_DRIVE = 3'h3,
		PPFC_FLD_FSEL = 3'h4
	} ppfc_field_t;
	typedef enum logic [1:0] {
		PPFC_RST_HOLD = 2'h0,
		PPFC_RST_WAIT = 2'h1,
		PPFC_RST_RUN = 2'h3
	} ppfc_rst_t;
	function automatic logic ppfc_has_drive_cfg(input int idx);
		logic hit;
		hit = 1'b0;
		for (int c = 0; c < PPFC_NCH; c++) begin
			if (idx == PPFC_TX_IDX[c] || idx == PPFC_CK_IDX[c]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : ppfc_has_drive_cfg
endpackage : ppfc_pkg
`default_nettype wire

/* File: hdl/ppfc_top.sv */
`default_nettype none
module ppfc_top import ppfc_pkg::*; (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic RESET_IN_N,
	input wire logic AUTO_RESET_SELECT,
	input wire logic AUTO_RESET_REQ,
	input wire logic CLK_STABLE,
	input wire logic [PPFC_NBITS-1:0] PIN_IN,
	input wire logic [PPFC_NBITS-1:0] CFG_WE,
	input wire ppfc_field_t CFG_FIELD,
	input wire logic [PPFC_NBITS-1:0] CFG_WDATA,
	input wire logic [PPFC_NCH-1:0] SERIAL_TX_EN,
	input wire logic [PPFC_NCH-1:0] SERIAL_RX_EN,
	input wire logic [PPFC_NCH-1:0] SERIAL_CLK_MASTER,
	input wire logic [PPFC_NCH-1:0] SERIAL_UART,
	input wire logic SERIAL4_I2C,
	input wire logic [PPFC_NCH-1:0] SERIAL_TX_DATA,
	input wire logic [PPFC_NCH-1:0] SERIAL_CLK_OUT,
	output logic [PPFC_NBITS-1:0] PIN_OUT,
	output logic [PPFC_NBITS-1:0] PIN_OE,
	output logic [PPFC_NBITS-1:0] PIN_PULLUP,
	output logic [PPFC_NBITS-1:0] READ_DATA,
	output logic [PPFC_NCH-1:0] SERIAL_RX_DATA,
	output logic [PPFC_NCH-1:0] SERIAL_CLK_IN,
	output logic PORT2_BIT7_SHARED_RESET,
	output logic AUTO_RESET_EN,
	output logic SYS_RESET_N,
	output logic RESET_START
);
	logic [PPFC_NBITS-1:0] alt_en;
	logic [PPFC_NBITS-1:0] alt_data;
	logic [PPFC_NBITS-1:0] pin_sync;

	logic [PPFC_NCH-1:0] rx_r;
	logic [PPFC_NCH-1:0] rx_nxt;
	logic [PPFC_NCH-1:0] ck_r;
	logic [PPFC_NCH-1:0] ck_nxt;
	logic [PPFC_NCH-1:0] uart_mode;

	logic rin_meta_r;
	logic rin_sync_r;
	logic ars_meta_r;
	logic ars_sync_r;

	logic p27_r;
	logic p27_nxt;
	logic aren_r;
	logic aren_nxt;
	logic srst_r;
	logic srst_nxt;
	logic start_r;
	logic start_nxt;
	logic reset_cause;
	logic clr;
	ppfc_rst_t rst_state_r;
	ppfc_rst_t rst_state_nxt;

	// pin-side inputs pass two flops before any logic looks at them
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rin_meta_r <= 1'b0;
			rin_sync_r <= 1'b0;
			ars_meta_r <= 1'b0;
			ars_sync_r <= 1'b0;
		end else begin
			rin_meta_r <= RESET_IN_N;
			rin_sync_r <= rin_meta_r;
			ars_meta_r <= AUTO_RESET_SELECT;
			ars_sync_r <= ars_meta_r;
		end
	end

	// reset pin sequencing
	// an auto reset request, while auto reset is enabled, takes the same path as a low reset pin
	assign reset_cause = ~rin_sync_r | (aren_r & AUTO_RESET_REQ);
	always_comb begin
		rst_state_nxt = rst_state_r;
		start_nxt = 1'b0;
		case (rst_state_r)
			PPFC_RST_HOLD: begin
				if (!reset_cause) begin
					rst_state_nxt = PPFC_RST_WAIT;
				end
			end
			PPFC_RST_WAIT: begin
				if (CLK_STABLE) begin
					rst_state_nxt = PPFC_RST_RUN;
					start_nxt = 1'b1;
				end
			end
			PPFC_RST_RUN: rst_state_nxt = PPFC_RST_RUN;
			default: rst_state_nxt = PPFC_RST_HOLD;
		endcase
		if (reset_cause) begin
			rst_state_nxt = PPFC_RST_HOLD;
			start_nxt = 1'b0;
		end
		// system stays in reset through the stabilisation wait too
		srst_nxt = (rst_state_nxt == PPFC_RST_RUN);
	end
	// cells clear on every cycle of hold, so a write made then is lost
	assign clr = (rst_state_r == PPFC_RST_HOLD);

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_state_r <= PPFC_RST_HOLD;
			start_r <= 1'b0;
			srst_r <= 1'b0;
		end else begin
			rst_state_r <= rst_state_nxt;
			start_r <= start_nxt;
			srst_r <= srst_nxt;
		end
	end

	// side flags follow their synchronised pins, apart from the sequencer state
	always_comb begin
		aren_nxt = ars_sync_r;
		// shared reset pin is only ever read, never driven
		p27_nxt = rin_sync_r;
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			aren_r <= 1'b0;
			p27_r <= 1'b0;
		end else begin
			aren_r <= aren_nxt;
			p27_r <= p27_nxt;
		end
	end

	// serial take-over of port bits; untouched bits keep plain port behaviour
	assign uart_mode = SERIAL_UART & PPFC_UART_CAP;
	always_comb begin
		alt_en = '0;
		alt_data = '0;
		rx_nxt = rx_r;
		ck_nxt = ck_r;
		for (int c = 0; c < PPFC_NCH; c++) begin
			alt_en[PPFC_TX_IDX[c]] = SERIAL_TX_EN[c];
			alt_data[PPFC_TX_IDX[c]] = SERIAL_TX_DATA[c];
			// UART has no clock pin, so it stays a port bit
			alt_en[PPFC_CK_IDX[c]] = SERIAL_CLK_MASTER[c] & ~uart_mode[c];
			alt_data[PPFC_CK_IDX[c]] = SERIAL_CLK_OUT[c];
			// idle-high when input is off so the serial core sees no spurious edges
			rx_nxt[c] = SERIAL_RX_EN[c] ? pin_sync[PPFC_RX_IDX[c]] : 1'b1;
			ck_nxt[c] = (SERIAL_CLK_MASTER[c] | uart_mode[c]) ? 1'b1 : pin_sync[PPFC_CK_IDX[c]];
		end
		if (SERIAL4_I2C) begin
			// I2C data returns on the transmit pin; clock is always read back for stretching
			rx_nxt[PPFC_I2C_CH] = SERIAL_RX_EN[PPFC_I2C_CH] ? pin_sync[PPFC_TX_IDX[PPFC_I2C_CH]] : 1'b1;
			ck_nxt[PPFC_I2C_CH] = pin_sync[PPFC_CK_IDX[PPFC_I2C_CH]];
			alt_en[PPFC_CK_IDX[PPFC_I2C_CH]] = SERIAL_CLK_MASTER[PPFC_I2C_CH];
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_r <= '1;
			ck_r <= '1;
		end else begin
			rx_r <= rx_nxt;
			ck_r <= ck_nxt;
		end
	end

	// one cell per port bit; flat index layout gives the port widths
	for (genvar i = 0; i < PPFC_NBITS; i++) begin : g_bit
		ppfc_pin_cell #(
			.HAS_DRIVE_CFG(ppfc_has_drive_cfg(i))
		) u_cell (
			.clk(MCLK),
			.rst_n(RST_N),
			.clr(clr),
			.pin_in(PIN_IN[i]),
			.we(CFG_WE[i]),
			.field(CFG_FIELD),
			.wd(CFG_WDATA[i]),
			.alt_en(alt_en[i]),
			.alt_data(alt_data[i]),
			.pin_out(PIN_OUT[i]),
			.pin_oe(PIN_OE[i]),
			.pull_en(PIN_PULLUP[i]),
			.rd(READ_DATA[i]),
			.sync(pin_sync[i])
		);
	end

	assign SERIAL_RX_DATA = rx_r;
	assign SERIAL_CLK_IN = ck_r;
	assign PORT2_BIT7_SHARED_RESET = p27_r;
	assign AUTO_RESET_EN = aren_r;
	assign SYS_RESET_N = srst_r;
	assign RESET_START = start_r;
endmodule : ppfc_top
`default_nettype wire

/* File: test/ppfc_board.sv */
`default_nettype none
module ppfc_board import ppfc_pkg::*; (
	input wire logic clk,
	input wire logic [PPFC_NBITS-1:0] pin_out,
	input wire logic [PPFC_NBITS-1:0] pin_oe,
	input wire logic [PPFC_NBITS-1:0] pull_en,
	input wire logic [PPFC_NBITS-1:0] ext_en,
	input wire logic [PPFC_NBITS-1:0] ext_val,
	output logic [PPFC_NBITS-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// a floating pin flips every cycle so it never reads as a steady level
	logic [PPFC_NBITS-1:0] flt_r = '0;
	always @(posedge clk) flt_r <= ~flt_r;
	// the pin's own driver wins; open-drain bits only pull low
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & (pull_en | flt_r))));
endmodule : ppfc_board
`default_nettype wire

/* File: test/ppfc_top_assertions.sv */
`default_nettype none
module ppfc_top_assertions import ppfc_pkg::*; (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic RESET_IN_N,
	input wire logic AUTO_RESET_SELECT,
	input wire logic CLK_STABLE,
	input wire logic [PPFC_NBITS-1:0] PIN_IN,
	input wire logic [PPFC_NCH-1:0] SERIAL_RX_EN,
	input wire logic [PPFC_NCH-1:0] SERIAL_CLK_MASTER,
	input wire logic [PPFC_NBITS-1:0] PIN_OUT,
	input wire logic [PPFC_NBITS-1:0] PIN_OE,
	input wire logic [PPFC_NBITS-1:0] PIN_PULLUP,
	input wire logic [PPFC_NBITS-1:0] READ_DATA,
	input wire logic [PPFC_NCH-1:0] SERIAL_RX_DATA,
	input wire logic [PPFC_NCH-1:0] SERIAL_CLK_IN,
	input wire logic PORT2_BIT7_SHARED_RESET,
	input wire logic AUTO_RESET_EN,
	input wire logic SYS_RESET_N,
	input wire logic RESET_START
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	a_pullup_input: assert property ((PIN_PULLUP & PIN_OE) == '0) else $error("pull-up on driven pin");
	a_hold_clears: assert property (!RESET_IN_N [*7] |-> PIN_OE == '0 && PIN_PULLUP == '0 && !SYS_RESET_N)
		else $error("hold not cleared");
	a_start_pulse: assert property ($rose(SYS_RESET_N) |-> RESET_START && $past(CLK_STABLE) ##1 !RESET_START)
		else $error("bad start pulse");
	a_shared_pin: assert property ($changed(PORT2_BIT7_SHARED_RESET) |-> PORT2_BIT7_SHARED_RESET == $past(RESET_IN_N, 3))
		else $error("shared pin level");
	a_auto_sel: assert property ($stable(AUTO_RESET_SELECT) [*4] |-> AUTO_RESET_EN == AUTO_RESET_SELECT)
		else $error("auto reset enable");
	a_rx_follow: assert property (SERIAL_RX_EN[0] [*4] |-> SERIAL_RX_DATA[0] == $past(PIN_IN[24], 3))
		else $error("rx data");
	a_clk_master: assert property (SERIAL_CLK_MASTER[0] [*2] |-> SERIAL_CLK_IN[0]) else $error("clock in");
	a_read_input: assert property (!PIN_OE[71] [*5] |-> READ_DATA[71] == $past(PIN_IN[71], 3))
		else $error("input read");
	a_read_latch: assert property (PIN_OE[71] [*3] |-> READ_DATA[71] == PIN_OUT[71]) else $error("latch read");
	c_start: cover property (RESET_START);
	c_rx_low: cover property (SERIAL_RX_EN[0] && !SERIAL_RX_DATA[0]);
	c_auto: cover property (AUTO_RESET_EN && !SYS_RESET_N);
endmodule : ppfc_top_assertions
bind ppfc_top ppfc_top_assertions i_ppfc_top_assertions (.MCLK, .RST_N, .RESET_IN_N, .AUTO_RESET_SELECT,
	.CLK_STABLE, .PIN_IN, .SERIAL_RX_EN, .SERIAL_CLK_MASTER, .PIN_OUT, .PIN_OE, .PIN_PULLUP, .READ_DATA,
	.SERIAL_RX_DATA, .SERIAL_CLK_IN, .PORT2_BIT7_SHARED_RESET, .AUTO_RESET_EN, .SYS_RESET_N, .RESET_START);
`default_nettype wire

/* File: test/tb_ppfc_top.sv */
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb_ppfc_top import ppfc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int N = PPFC_NBITS;
	logic MCLK = 1'b0, RST_N = 1'b0, RESET_IN_N = 1'b0, CLK_STABLE = 1'b0, SERIAL4_I2C = 1'b0;
	logic AUTO_RESET_SELECT = 1'b0, AUTO_RESET_REQ = 1'b0;
	logic [N-1:0] PIN_IN, CFG_WE = '0, CFG_WDATA = '0, ext_en = '0, ext_val = '0;
	logic [N-1:0] PIN_OUT, PIN_OE, PIN_PULLUP, READ_DATA;
	ppfc_field_t CFG_FIELD = PPFC_FLD_LATCH;
	logic [3:0] SERIAL_TX_EN = '0, SERIAL_RX_EN = '0, SERIAL_CLK_MASTER = '0, SERIAL_UART = '0;
	logic [3:0] SERIAL_TX_DATA = '0, SERIAL_CLK_OUT = '0, SERIAL_RX_DATA, SERIAL_CLK_IN;
	logic PORT2_BIT7_SHARED_RESET, AUTO_RESET_EN, SYS_RESET_N, RESET_START;
	logic [N-1:0] d = 72'h96_a53c_0ff0_5aa5_c33c, l = 72'h3c_5a96_f00f_a55a_33cc;
	int n_errors = 0, cmp_count = 0;
	ppfc_top i_ppfc_top (.*);
	ppfc_board i_ppfc_board (.clk(MCLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pull_en(PIN_PULLUP),
		.ext_en(ext_en), .ext_val(ext_val), .pin_in(PIN_IN));
	always #25 MCLK = ~MCLK;
	task automatic test_done;
		if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic wr(input ppfc_field_t f, input logic [N-1:0] m, input logic [N-1:0] v);
		@(negedge MCLK);
		CFG_FIELD = f;
		CFG_WE = m;
		CFG_WDATA = v;
		@(negedge MCLK);
		CFG_WE = '0;
	endtask : wr
	task automatic st;
		repeat (4) @(negedge MCLK);
	endtask : st
	// bounded: a start pulse that never comes ends the run as a failure
	task automatic wait_start;
		int i;
		for (i = 0; i < 20 && RESET_START !== 1'b1; i++) @(negedge MCLK);
		if (i == 20) begin
			n_errors++;
			test_done();
		end
		`CHK(SYS_RESET_N, 1'b1)
	endtask : wait_start
	initial begin
		repeat (5) @(negedge MCLK);
		RST_N = 1'b1;
		st();
		`CHK({SYS_RESET_N, PIN_OE, PIN_PULLUP}, {1'b0, {N{1'b0}}, {N{1'b0}}})
		wr(PPFC_FLD_DIR, '1, '1);
		RESET_IN_N = 1'b1;
		st();
		`CHK({SYS_RESET_N, PIN_OE}, {1'b0, {N{1'b0}}})
		CLK_STABLE = 1'b1;
		wait_start();
		wr(PPFC_FLD_PULLUP, '1, '1);
		wr(PPFC_FLD_LATCH, '1, l);
		wr(PPFC_FLD_DIR, '1, d);
		st();
		`CHK({PIN_OE, PIN_OUT & d, PIN_PULLUP}, {d, l & d, ~d})
		`CHK(READ_DATA, (l & d) | ~d)
		ext_en = '1;
		ext_val = l;
		wr(PPFC_FLD_PULLUP, '1, '0);
		wr(PPFC_FLD_LATCH, '1, ~l);
		st();
		`CHK({READ_DATA, PIN_PULLUP}, {l ^ d, {N{1'b0}}})
		wr(PPFC_FLD_DIR, '1, '1);
		st();
		`CHK(PIN_OUT, ~l)
		wr(PPFC_FLD_FSEL, 72'h18_0280_0000, 72'h18_0280_0000);
		SERIAL_TX_EN = 4'h9;
		for (int k = 0; k < 2; k++) begin
			SERIAL_TX_DATA = {4{k[0]}};
			st();
			`CHK({PIN_OE[23], PIN_OUT[23], PIN_OUT[24]}, {1'b1, k[0], ~l[24]})
		end
		wr(PPFC_FLD_DRIVE, '1, '1);
		SERIAL4_I2C = 1'b1;
		SERIAL_RX_EN = 4'h9;
		ext_val[35] = 1'b0;
		st();
		`CHK({PIN_OE[23], PIN_OUT[23], PIN_OE[71]}, 3'b001)
		`CHK(SERIAL_RX_DATA, {1'b0, 2'b11, ~l[24]})
		SERIAL_CLK_MASTER = 4'h1;
		SERIAL_UART = 4'h2;
		for (int k = 0; k < 2; k++) begin
			SERIAL_CLK_OUT = {4{k[0]}};
			st();
			`CHK({PIN_OE[25], SERIAL_CLK_IN[1:0]}, {~k[0], 2'b11})
		end
		AUTO_RESET_SELECT = 1'b1;
		AUTO_RESET_REQ = 1'b1;
		repeat (2) st();
		`CHK({AUTO_RESET_EN, SYS_RESET_N, PIN_OE}, {2'b10, {N{1'b0}}})
		AUTO_RESET_REQ = 1'b0;
		wait_start();
		AUTO_RESET_SELECT = 1'b0;
		st();
		AUTO_RESET_REQ = 1'b1;
		st();
		`CHK({AUTO_RESET_EN, SYS_RESET_N}, 2'b01)
		wr(PPFC_FLD_DIR, '1, '1);
		st();
		`CHK(PIN_OE, {N{1'b1}})
		RESET_IN_N = 1'b0;
		repeat (2) st();
		`CHK({PORT2_BIT7_SHARED_RESET, SYS_RESET_N, PIN_OE}, {2'b00, {N{1'b0}}})
		RESET_IN_N = 1'b1;
		wait_start();
		`CHK(PORT2_BIT7_SHARED_RESET, 1'b1)
		test_done();
	end
endmodule : tb_ppfc_top
`default_nettype wire
